// ===== posm_params.svh
// constants for the pin output source multiplexer
`ifndef POSM_PARAMS_SVH
`define POSM_PARAMS_SVH
`define POSM_ADDR_PIN5 8'h15
`define POSM_ADDR_PIN6 8'h16
`define POSM_CTRL_RESET 8'h00
`define POSM_SEL_HI 7
`define POSM_SEL_LO 5
`define POSM_SRC_HI 4
`define POSM_SRC_LO 2
`define POSM_VAL_BIT 1
`define POSM_EN_BIT 0
`define POSM_SRC_STATUS 3'h4
`define POSM_SRC_RSVD 3'h5
`define POSM_SRC_TX0 3'h6
`define POSM_SRC_TX1 3'h7
`define POSM_SEL_LOCK 3'h4
`define POSM_SEL_PASS 3'h5
`define POSM_SEL_FV 3'h6
`define POSM_SEL_LV 3'h7
`define POSM_ST_VALUE 3'h0
`define POSM_ST_LOCK_OR 3'h1
`define POSM_ST_LOCK_AND 3'h2
`define POSM_ST_PASS_AND 3'h3
`define POSM_ST_SYNC5 3'h4
`define POSM_ST_SYNC6 3'h5
`define POSM_TX_PASS_AND 3'h0
`define POSM_TX_PASS_OR 3'h1
`define POSM_TX_FV 3'h2
`define POSM_TX_LV 3'h3
`define POSM_TX_SYNCED 3'h4
`define POSM_TX_IRQ 3'h5
`endif

// ===== posm_pkg.sv
// types for the pin output source multiplexer
package posm_pkg;
   typedef struct packed {
      logic [2:0] signal_select;
      logic [2:0] source_group;
      logic register_value;
      logic drive_enable;
   } posm_ctrl_t;
   typedef struct packed {
      logic [3:0] remote_in;
      logic lock;
      logic pass;
      logic frame_valid;
      logic line_valid;
   } posm_rx_t;
   typedef struct packed {
      logic pass_and;
      logic pass_or;
      logic frame_valid;
      logic line_valid;
      logic synced;
      logic irq;
   } posm_tx_t;
endpackage

// ===== posm_pin_select.sv
// one pin's source selection, purely combinational
`timescale 1ns/1ps
`include "posm_params.svh"
module posm_pin_select
   import posm_pkg::*;
#(
   parameter logic [2:0] SYNC_CODE = `POSM_ST_SYNC5
) (
   input wire posm_ctrl_t ctrl,
   input wire posm_rx_t [3:0] rx,
   input wire posm_tx_t [1:0] tx,
   input wire logic [3:0] rx_enabled,
   input wire logic frame_sync_pulse,
   output logic data
);
   function automatic logic rx_pick(input posm_rx_t p, input logic [2:0] s);
      case (s)
         `POSM_SEL_LOCK: rx_pick = p.lock;
         `POSM_SEL_PASS: rx_pick = p.pass;
         `POSM_SEL_FV: rx_pick = p.frame_valid;
         `POSM_SEL_LV: rx_pick = p.line_valid;
         default: rx_pick = p.remote_in[s[1:0]];
      endcase
   endfunction
   function automatic logic tx_pick(input posm_tx_t t, input logic [2:0] s);
      case (s)
         `POSM_TX_PASS_AND: tx_pick = t.pass_and;
         `POSM_TX_PASS_OR: tx_pick = t.pass_or;
         `POSM_TX_FV: tx_pick = t.frame_valid;
         `POSM_TX_LV: tx_pick = t.line_valid;
         `POSM_TX_SYNCED: tx_pick = t.synced;
         `POSM_TX_IRQ: tx_pick = t.irq;
         default: tx_pick = 1'b0;
      endcase
   endfunction
   logic [3:0] lock_m;
   logic [3:0] pass_m;
   logic any_en;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         lock_m[i] = rx[i].lock;
         pass_m[i] = rx[i].pass;
      end
      any_en = |rx_enabled;
      data = 1'b0;
      case (ctrl.source_group)
         `POSM_SRC_STATUS: begin
            if (ctrl.signal_select == `POSM_ST_VALUE) begin
               data = ctrl.register_value;
            end else if (ctrl.signal_select == `POSM_ST_LOCK_OR) begin
               data = |(lock_m & rx_enabled);
            end else if (ctrl.signal_select == `POSM_ST_LOCK_AND) begin
               data = any_en & &(lock_m | ~rx_enabled);
            end else if (ctrl.signal_select == `POSM_ST_PASS_AND) begin
               data = any_en & &(pass_m | ~rx_enabled);
            end else if (ctrl.signal_select == SYNC_CODE) begin
               data = frame_sync_pulse;
            end
         end
         `POSM_SRC_RSVD: data = 1'b0;
         `POSM_SRC_TX0: data = tx_pick(tx[0], ctrl.signal_select);
         `POSM_SRC_TX1: data = tx_pick(tx[1], ctrl.signal_select);
         default: data = rx_pick(rx[ctrl.source_group[1:0]], ctrl.signal_select);
      endcase
   end
endmodule

// ===== posm_top.sv
// control registers and registered outputs for pins 5 and 6
`timescale 1ns/1ps
`include "posm_params.svh"
// What this block does
// - source field bits 4:2 pick receive port 0-3, status, or transmit port 0/1
// - receive source, select 0-3 outputs that port's forwarded remote input
// - receive source, select 4-7 outputs lock, pass, frame valid, line valid
// - status source, select 0 outputs the register value bit
// - status source, select 1/2 output OR/AND of enabled ports' lock
// - status source, select 3 outputs AND of enabled ports' pass
// - pin 5 status select 4 outputs frame sync; 5-7 reserved
// - pin 6 frame sync code is ambiguous; a parameter picks it, flagged
// - transmit source, select 0/1 output AND/OR of its receive pass status
// - transmit source, select 2/3 output its frame and line valid
// - transmit source, select 4 synchronized, 5 interrupt, 6-7 reserved
// - bit 1 is the value driven when the register value is selected
// - bit 0 enables driving; clear means the pin is not driven
module posm_top
   import posm_pkg::*;
#(
   parameter logic [2:0] PIN6_SYNC_CODE = `POSM_ST_SYNC6
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire posm_rx_t [3:0] rx,
   input wire posm_tx_t [1:0] tx,
   input wire logic [3:0] rx_enabled,
   input wire logic frame_sync_pulse,
   output logic pin5_out,
   output logic pin5_oe,
   output logic pin6_out,
   output logic pin6_oe
);
   posm_ctrl_t pin5_output_control;
   posm_ctrl_t pin6_output_control;
   logic next_pin5;
   logic next_pin6;
   logic [3:0] lock_all;
   logic [3:0] pass_all;

   // register writes from the serial control bus
   always_ff @(posedge clock) begin
      if (reset) begin
         pin5_output_control <= `POSM_CTRL_RESET;
         pin6_output_control <= `POSM_CTRL_RESET;
      end else if (reg_write) begin
         if (reg_addr == `POSM_ADDR_PIN5) begin
            pin5_output_control <= reg_wdata;
         end
         if (reg_addr == `POSM_ADDR_PIN6) begin
            pin6_output_control <= reg_wdata;
         end
      end
   end

   // read data registered; unmapped addresses read zero
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_addr == `POSM_ADDR_PIN5) begin
         reg_rdata <= pin5_output_control;
      end else if (reg_addr == `POSM_ADDR_PIN6) begin
         reg_rdata <= pin6_output_control;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   posm_pin_select #(.SYNC_CODE(`POSM_ST_SYNC5)) u_pin5 (
      .ctrl(pin5_output_control),
      .rx(rx),
      .tx(tx),
      .rx_enabled(rx_enabled),
      .frame_sync_pulse(frame_sync_pulse),
      .data(next_pin5)
   );
   posm_pin_select #(.SYNC_CODE(PIN6_SYNC_CODE)) u_pin6 (
      .ctrl(pin6_output_control),
      .rx(rx),
      .tx(tx),
      .rx_enabled(rx_enabled),
      .frame_sync_pulse(frame_sync_pulse),
      .data(next_pin6)
   );

   // one register stage so pins never glitch on select changes
   always_ff @(posedge clock) begin
      if (reset) begin
         pin5_out <= 1'b0;
         pin5_oe <= 1'b0;
         pin6_out <= 1'b0;
         pin6_oe <= 1'b0;
      end else begin
         pin5_oe <= pin5_output_control.drive_enable;
         pin6_oe <= pin6_output_control.drive_enable;
         pin5_out <= pin5_output_control.drive_enable & next_pin5;
         pin6_out <= pin6_output_control.drive_enable & next_pin6;
      end
   end

   chk_oe_follows_en: assert property (@(posedge clock) disable iff (reset)
      ##1 pin5_oe == $past(pin5_output_control.drive_enable))
      else $error("pin5 enable mismatch");
   chk_undriven_low: assert property (@(posedge clock) disable iff (reset)
      !pin6_oe |-> !pin6_out)
      else $error("pin6 data while undriven");
   chk_value_bit: assert property (@(posedge clock) disable iff (reset)
      (pin5_output_control == {3'h0, `POSM_SRC_STATUS, 2'b11}) [*2] |-> pin5_out)
      else $error("pin5 value bit not driven");
   chk_rsvd_src_low: assert property (@(posedge clock) disable iff (reset)
      pin6_output_control.source_group == `POSM_SRC_RSVD |=> !pin6_out)
      else $error("reserved source not low");
   chk_rx_lock: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_SEL_LOCK, 3'h1, 2'b01} |=> pin5_out == $past(rx[1].lock))
      else $error("rx lock not routed");
   chk_rx_remote: assert property (@(posedge clock) disable iff (reset)
      pin6_output_control == {3'h2, 3'h3, 2'b01} |=> pin6_out == $past(rx[3].remote_in[2]))
      else $error("remote input not routed");
   chk_tx_irq: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_TX_IRQ, `POSM_SRC_TX1, 2'b01} |=> pin5_out == $past(tx[1].irq))
      else $error("tx irq not routed");
   chk_lock_or: assert property (@(posedge clock) disable iff (reset)
      pin6_output_control == {`POSM_ST_LOCK_OR, `POSM_SRC_STATUS, 2'b01}
      |=> pin6_out == $past(|({rx[3].lock, rx[2].lock, rx[1].lock, rx[0].lock} & rx_enabled)))
      else $error("lock or wrong");
   chk_sync5: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_ST_SYNC5, `POSM_SRC_STATUS, 2'b01}
      |=> pin5_out == $past(frame_sync_pulse))
      else $error("frame sync not routed");
   chk_reset_state: assert property (@(posedge clock)
      $fell(reset) |-> pin5_output_control == 8'h00 && !pin5_oe && !pin6_oe)
      else $error("reset state wrong");

   // flat views of the per-port status, read only by the checks below
   assign lock_all = {rx[3].lock, rx[2].lock, rx[1].lock, rx[0].lock};
   assign pass_all = {rx[3].pass, rx[2].pass, rx[1].pass, rx[0].pass};
   chk_oe6_follows_en: assert property (@(posedge clock) disable iff (reset)
      ##1 pin6_oe == $past(pin6_output_control.drive_enable))
      else $error("pin6 enable mismatch");
   chk_pin5_undriven: assert property (@(posedge clock) disable iff (reset)
      !pin5_oe |-> !pin5_out)
      else $error("pin5 data while undriven");
   chk_write_pin5: assert property (@(posedge clock) disable iff (reset)
      reg_write && reg_addr == `POSM_ADDR_PIN5 |=> pin5_output_control == $past(reg_wdata))
      else $error("pin5 write lost");
   chk_write_pin6: assert property (@(posedge clock) disable iff (reset)
      reg_write && reg_addr == `POSM_ADDR_PIN6 |=> pin6_output_control == $past(reg_wdata))
      else $error("pin6 write lost");
   chk_write_ignored: assert property (@(posedge clock) disable iff (reset)
      reg_write && reg_addr != `POSM_ADDR_PIN5 && reg_addr != `POSM_ADDR_PIN6
      |=> $stable(pin5_output_control) && $stable(pin6_output_control))
      else $error("unmapped write changed a control");
   chk_read_pin5: assert property (@(posedge clock) disable iff (reset)
      reg_addr == `POSM_ADDR_PIN5 |=> reg_rdata == $past(pin5_output_control))
      else $error("pin5 read wrong");
   chk_read_pin6: assert property (@(posedge clock) disable iff (reset)
      reg_addr == `POSM_ADDR_PIN6 |=> reg_rdata == $past(pin6_output_control))
      else $error("pin6 read wrong");
   chk_read_unmapped: assert property (@(posedge clock) disable iff (reset)
      reg_addr != `POSM_ADDR_PIN5 && reg_addr != `POSM_ADDR_PIN6
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_rx_remote5: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {3'h1, 3'h0, 2'b01} |=> pin5_out == $past(rx[0].remote_in[1]))
      else $error("pin5 remote input not routed");
   chk_rx_frame: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_SEL_FV, 3'h0, 2'b01}
      |=> pin5_out == $past(rx[0].frame_valid))
      else $error("rx frame valid not routed");
   chk_rx_line: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_SEL_LV, 3'h0, 2'b01}
      |=> pin5_out == $past(rx[0].line_valid))
      else $error("rx line valid not routed");
   chk_rx_pass: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_SEL_PASS, 3'h3, 2'b01}
      |=> pin5_out == $past(rx[3].pass))
      else $error("rx pass not routed");
   chk_lock_and: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_ST_LOCK_AND, `POSM_SRC_STATUS, 2'b01}
      |=> pin5_out == $past(|rx_enabled && &(lock_all | ~rx_enabled)))
      else $error("lock and wrong");
   chk_pass_and: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_ST_PASS_AND, `POSM_SRC_STATUS, 2'b01}
      |=> pin5_out == $past(|rx_enabled && &(pass_all | ~rx_enabled)))
      else $error("pass and wrong");
   chk_sync5_rsvd: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control.source_group == `POSM_SRC_STATUS
      && pin5_output_control.signal_select > `POSM_ST_SYNC5 |=> !pin5_out)
      else $error("reserved status select not low");
   chk_sync6: assert property (@(posedge clock) disable iff (reset)
      pin6_output_control == {PIN6_SYNC_CODE, `POSM_SRC_STATUS, 2'b01}
      |=> pin6_out == $past(frame_sync_pulse))
      else $error("pin6 frame sync not routed");
   chk_tx_pass_and: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_TX_PASS_AND, `POSM_SRC_TX0, 2'b01}
      |=> pin5_out == $past(tx[0].pass_and))
      else $error("tx pass and not routed");
   chk_tx_pass_or: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_TX_PASS_OR, `POSM_SRC_TX1, 2'b01}
      |=> pin5_out == $past(tx[1].pass_or))
      else $error("tx pass or not routed");
   chk_tx_frame: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_TX_FV, `POSM_SRC_TX0, 2'b01}
      |=> pin5_out == $past(tx[0].frame_valid))
      else $error("tx frame valid not routed");
   chk_tx_line: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_TX_LV, `POSM_SRC_TX0, 2'b01}
      |=> pin5_out == $past(tx[0].line_valid))
      else $error("tx line valid not routed");
   chk_tx_synced: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control == {`POSM_TX_SYNCED, `POSM_SRC_TX0, 2'b01}
      |=> pin5_out == $past(tx[0].synced))
      else $error("tx synchronized not routed");
   chk_tx_rsvd: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control.source_group[2:1] == 2'b11
      && pin5_output_control.signal_select[2:1] == 2'b11 |=> !pin5_out)
      else $error("reserved tx select not low");
   chk_rsvd5_low: assert property (@(posedge clock) disable iff (reset)
      pin5_output_control.source_group == `POSM_SRC_RSVD |=> !pin5_out)
      else $error("pin5 reserved source not low");
   chk_reset_outputs: assert property (@(posedge clock)
      $fell(reset) |-> pin6_output_control == 8'h00 && reg_rdata == 8'h00
      && !pin5_out && !pin6_out)
      else $error("reset outputs wrong");
   cov_pin5_enabled: cover property (@(posedge clock) disable iff (reset) $rose(pin5_oe));
   cov_pin6_tx: cover property (@(posedge clock) disable iff (reset)
      pin6_oe && pin6_output_control.source_group == `POSM_SRC_TX0);
   cov_status_out: cover property (@(posedge clock) disable iff (reset)
      pin5_oe && pin5_output_control.source_group == `POSM_SRC_STATUS && pin5_out);
endmodule

// ===== posm_pin_sink.sv
// far-side model: the pad that the pin drives, as seen by outside logic
`timescale 1ns/1ps
module posm_pin_sink (
   input wire logic clock,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic level
);
   logic last = 1'b0;
   always @(posedge clock) begin
      if (pin_oe) begin
         last <= pin_out;
      end
   end
   // no pull on the pad, so an undriven pin shows the inverse of its last value
   assign level = pin_oe ? pin_out : ~last;
endmodule

// ===== pin_output_source_mux_tb.sv
// self-checking bench for the pin output source multiplexer
`timescale 1ns/1ps
module pin_output_source_mux_tb import posm_pkg::*;;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic reg_write = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   posm_rx_t [3:0] rx = 32'h05009f6a;
   posm_tx_t [1:0] tx = 12'h56a;
   logic [3:0] rx_enabled = 4'h3;
   logic frame_sync_pulse = 1'b1;
   logic pin5_out, pin5_oe, pin6_out, pin6_oe, lvl5, lvl6;
   int n_errors = 0;
   int checks = 0;
   // bit 8 is the expected pin level, bits 7:0 the control byte
   logic [8:0] tab [0:30] = '{9'h001, 9'h121, 9'h141, 9'h061, 9'h185, 9'h1ad, 9'h1c1,
      9'h0e1, 9'h113, 9'h011, 9'h131, 9'h151, 9'h071, 9'h191, 9'h0b1, 9'h0d1,
      9'h0f1, 9'h015, 9'h0f5, 9'h017, 9'h119, 9'h039, 9'h159, 9'h079, 9'h199,
      9'h0b9, 9'h0d9, 9'h0f9, 9'h01d, 9'h13d, 9'h1bd};

   always #10 clock = ~clock;

   posm_top dut (.clock(clock), .reset(reset), .reg_write(reg_write),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx(rx),
      .tx(tx), .rx_enabled(rx_enabled), .frame_sync_pulse(frame_sync_pulse),
      .pin5_out(pin5_out), .pin5_oe(pin5_oe), .pin6_out(pin6_out), .pin6_oe(pin6_oe));
   posm_pin_sink sink5 (.clock(clock), .pin_out(pin5_out), .pin_oe(pin5_oe), .level(lvl5));
   posm_pin_sink sink6 (.clock(clock), .pin_out(pin6_out), .pin_oe(pin6_oe), .level(lvl6));

   task automatic cmp_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // pins follow one edge after the control register takes the write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      @(posedge clock);
      #1;
      d = reg_rdata;
   endtask

   task automatic final_report;
      $display("errors=%0d checks=%0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // whole run is about 140 cycles; this leaves wide margin
   initial begin
      #100us;
      n_errors++;
      final_report();
   end

   initial begin
      logic [7:0] d;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      #1;
      cmp_bit(pin5_oe, 1'b0);
      rd(8'h15, d);
      cmp_byte(d, 8'h00);
      foreach (tab[i]) begin
         wr(8'h15, tab[i][7:0]);
         cmp_bit(pin5_oe, 1'b1);
         cmp_bit(lvl5, tab[i][8]);
      end
      rd(8'h15, d);
      cmp_byte(d, 8'hbd);
      wr(8'h16, 8'h4d);
      cmp_bit(lvl6, 1'b0);
      wr(8'h16, 8'h31);
      cmp_bit(lvl6, 1'b1);
      wr(8'h16, 8'h17);
      cmp_bit(lvl6, 1'b0);
      wr(8'h16, 8'h19);
      cmp_bit(lvl6, 1'b1);
      wr(8'h16, 8'hb1);
      cmp_bit(lvl6, 1'b1);
      wr(8'h16, 8'h91);
      cmp_bit(lvl6, 1'b0);
      cmp_bit(lvl5, 1'b1);
      wr(8'h15, 8'h12);
      cmp_bit(pin5_oe, 1'b0);
      cmp_bit(pin5_out, 1'b0);
      cmp_bit(lvl5, 1'b0);
      cmp_bit(pin6_oe, 1'b1);
      wr(8'h17, 8'hff);
      rd(8'h17, d);
      cmp_byte(d, 8'h00);
      rd(8'h16, d);
      cmp_byte(d, 8'h91);
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      rd(8'h16, d);
      cmp_byte(d, 8'h00);
      cmp_bit(pin6_oe, 1'b0);
      final_report();
   end
endmodule
